/* File: verilog/digit_pkg.sv */
// constants and encodings for the counting display decade
// Behaviour
// - strobe low: latch follows the counter continuously.
// - strobe high: latch and display hold, counter keeps counting.
// - terminal count goes low at count nine with ripple enable low.
// - terminal count returns high at zero, stays high for one to eight.
// - ripple enable high forces terminal count high.
// - lookahead enable high stops counting.
// - ripple enable high stops counting.
// - latched zero with blank input low blanks digit, drives blank output low.
// - blank input ignored when latched value is not zero.
// - blank output low on force blank, or blank input low with zero.
// - blank output node is wired-AND with a pull-up and external drivers.
// - blank node low, from anyone, blanks the whole digit.
// - count up on rising count clock when both enables low, clear high.
// - clear low resets counter to zero and holds it.
// - force blank turns off segments and point, drives blank output low.
// - latched digit on four outputs weighted 1, 2, 4, 8.
package digit_pkg;
    localparam logic [3:0] COUNT_ZERO = 4'h0;
    localparam logic [3:0] COUNT_MAX = 4'h9;
    localparam logic [3:0] COUNT_STEP = 4'h1;
    localparam logic [6:0] SEG_OFF = 7'h00;
    localparam int SYNC_STAGES = 3;
    // idle pin levels, first pin is the count clock, last the blank node:
    // count clock, blank input and node rest high so reset makes no false edge
    localparam logic [8:0] PIN_IDLE = 9'h103;
    // segment bit positions, a..g
    localparam int SEG_A = 0;
    localparam int SEG_G = 6;
endpackage : digit_pkg

/* File: verilog/seg_decoder.sv */
// bcd to seven-segment pattern decoder
`timescale 1ns/1ps
module seg_decoder (
    // digit in
    input wire logic [3:0] digit,
    // pattern out, bit 0 = segment a
    output logic [6:0] segments
);
    // conventional shapes; codes above nine show nothing
    always_comb begin
        unique case (digit)
            4'h0: segments = 7'h3F;
            4'h1: segments = 7'h06;
            4'h2: segments = 7'h5B;
            4'h3: segments = 7'h4F;
            4'h4: segments = 7'h66;
            4'h5: segments = 7'h6D;
            4'h6: segments = 7'h7D;
            4'h7: segments = 7'h07;
            4'h8: segments = 7'h7F;
            4'h9: segments = 7'h6F;
            default: segments = digit_pkg::SEG_OFF;
        endcase
    end
endmodule : seg_decoder

/* File: verilog/digit_counter.sv */
// one decade: counter, latch, zero blanking and segment drive
`timescale 1ns/1ps
module digit_counter (
    // system
    input wire logic clk,
    input wire logic rst_n,
    // count control, all from pins
    input wire logic count_clk,
    input wire logic counter_clear_n,
    input wire logic lookahead_enable_n,
    input wire logic ripple_enable_n,
    input wire logic latch_hold_strobe,
    // display control, from pins
    input wire logic force_blank,
    input wire logic point_in,
    input wire logic zero_blank_in_n,
    // wired-AND blank node: level seen, low drive and its enable
    input wire logic zero_blank_node_in,
    output logic zero_blank_out_n,
    output logic zero_blank_oe,
    // data outputs
    output logic [3:0] latch_q,
    output logic terminal_count_n,
    output logic [6:0] segments,
    output logic point_on
);
    // three-stage synchronisers for every pin input
    localparam int NIN = 9;
    logic [NIN-1:0] pin_raw;
    logic [NIN-1:0] sync1_reg;
    logic [NIN-1:0] sync2_reg;
    logic [NIN-1:0] sync3_reg;
    logic [NIN-1:0] clean_reg;
    assign pin_raw = {count_clk, counter_clear_n, lookahead_enable_n, ripple_enable_n,
                      latch_hold_strobe, force_blank, point_in, zero_blank_in_n,
                      zero_blank_node_in};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_reg <= digit_pkg::PIN_IDLE;
            sync2_reg <= digit_pkg::PIN_IDLE;
            sync3_reg <= digit_pkg::PIN_IDLE;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // a change counts once stages two and three agree; reset values are PIN_IDLE
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_filt
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    clean_reg[gi] <= digit_pkg::PIN_IDLE[gi];
                end else if (sync2_reg[gi] == sync3_reg[gi]) begin
                    clean_reg[gi] <= sync3_reg[gi];
                end
            end
        end
    endgenerate

    logic cclk_s, clr_n_s, la_en_n_s, rp_en_n_s, hold_s, blank_s, dp_s, rbi_n_s, node_s;
    assign {cclk_s, clr_n_s, la_en_n_s, rp_en_n_s, hold_s, blank_s, dp_s, rbi_n_s,
            node_s} = clean_reg;

    // rising edge of the count clock, on the filtered level only
    logic cclk_prev_reg;
    logic count_edge;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cclk_prev_reg <= 1'b1;
        end else begin
            cclk_prev_reg <= cclk_s;
        end
    end
    assign count_edge = cclk_s && !cclk_prev_reg;

    // decade counter; enables are sampled at the edge, which is safe because
    // the controller only moves them while the count clock is high
    logic [3:0] count_reg;
    logic [3:0] count_next;
    always_comb begin
        if (count_reg == digit_pkg::COUNT_MAX) begin
            count_next = digit_pkg::COUNT_ZERO;
        end else begin
            count_next = 4'(count_reg + digit_pkg::COUNT_STEP);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= digit_pkg::COUNT_ZERO;
        end else if (!clr_n_s) begin
            count_reg <= digit_pkg::COUNT_ZERO;
        end else if (count_edge && !la_en_n_s && !rp_en_n_s) begin
            count_reg <= count_next;
        end
    end

    // latch: transparent with strobe low, holds with strobe high
    logic [3:0] latch_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latch_reg <= digit_pkg::COUNT_ZERO;
        end else if (!hold_s) begin
            latch_reg <= count_reg;
        end
    end // holding branch keeps latch_reg

    // terminal count follows the counter, not the latch
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            terminal_count_n <= 1'b1;
        end else if (rp_en_n_s) begin
            terminal_count_n <= 1'b1;
        end else begin
            terminal_count_n <= !(count_reg == digit_pkg::COUNT_MAX);
        end
    end

    // blank node: our own low drive, then the node as seen at the pin
    logic zero_latched;
    logic own_blank;
    assign zero_latched = (latch_reg == digit_pkg::COUNT_ZERO);
    assign own_blank = blank_s || (!rbi_n_s && zero_latched);

    // open-drain: drive low only, release to the pull-up otherwise
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            zero_blank_out_n <= 1'b1;
            zero_blank_oe <= 1'b0;
        end else begin
            zero_blank_out_n <= 1'b0;
            zero_blank_oe <= own_blank;
        end
    end

    // digit dark on own blank or node low from any party; the node view lags
    // by the synchroniser, so own_blank is also used directly
    logic dark;
    logic [6:0] pattern;
    assign dark = own_blank || !node_s;
    seg_decoder seg_decoder_i (
        .digit(latch_reg),
        .segments(pattern)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            segments <= digit_pkg::SEG_OFF;
            point_on <= 1'b0;
            latch_q <= digit_pkg::COUNT_ZERO;
        end else begin
            segments <= dark ? digit_pkg::SEG_OFF : pattern;
            point_on <= dp_s && !dark;
            latch_q <= latch_reg;
        end
    end
endmodule : digit_counter

/* File: sim/far_side.sv */
// far side: count clock source and the pulled-up blank node
`timescale 1ns/1ps
module far_side (
    // control
    input wire logic clk,
    input wire logic run,
    input wire logic zero_blank_oe,
    input wire logic ext_pull,
    // pins
    output logic count_clk,
    output logic zero_blank_node_in
);
    logic [2:0] ph_reg = 3'h0;
    // a started pulse always finishes whole, four cycles low then back high
    always_ff @(posedge clk) begin
        if (run || ph_reg != 3'h0) ph_reg <= ph_reg + 3'h1;
    end
    // idles high, so enables are only ever moved in the high phase
    assign count_clk = !ph_reg[2];
    // open-collector sinks against a pull-up
    assign zero_blank_node_in = !(zero_blank_oe || ext_pull);
endmodule : far_side

/* File: sim/digit_counter_asserts.sv */
// port assertions for the counting display decade
`timescale 1ns/1ps
module digit_counter_asserts (
    // watched ports
    input wire logic clk,
    input wire logic rst_n,
    input wire logic counter_clear_n,
    input wire logic lookahead_enable_n,
    input wire logic ripple_enable_n,
    input wire logic latch_hold_strobe,
    input wire logic force_blank,
    input wire logic zero_blank_in_n,
    input wire logic zero_blank_node_in,
    input wire logic zero_blank_oe,
    input wire logic [3:0] latch_q,
    input wire logic terminal_count_n,
    input wire logic [6:0] segments
);
    // pins cross a filter, so causes are held eight cycles first; step_wrap_a samples the strobe eight cycles back
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    step_wrap_a: assert property ($changed(latch_q) && !$past(latch_hold_strobe, 8) |->
        latch_q == $past(latch_q) + 4'h1 || latch_q == 4'h0) else $error("bad step");
    latch_hold_a: assert property (latch_hold_strobe [*8] |-> $stable(latch_q))
        else $error("hold lost");
    count_stop_a: assert property ((counter_clear_n && !latch_hold_strobe &&
        (lookahead_enable_n || ripple_enable_n)) [*8] |-> $stable(latch_q))
        else $error("counted");
    clear_zero_a: assert property ((!counter_clear_n && !latch_hold_strobe) [*8] |->
        latch_q == 4'h0) else $error("not cleared");
    force_dark_a: assert property (force_blank [*8] |-> segments == 7'h00 && zero_blank_oe)
        else $error("not dark");
    max_inhibit_a: assert property (ripple_enable_n [*8] |-> terminal_count_n)
        else $error("max count low");
    zero_supp_a: assert property ((latch_q == 4'h0 && !zero_blank_in_n) [*8] |->
        zero_blank_oe && segments == 7'h00) else $error("zero shown");
    node_dark_a: assert property (!zero_blank_node_in [*8] |-> segments == 7'h00)
        else $error("lit on low node");
endmodule : digit_counter_asserts

bind digit_counter digit_counter_asserts digit_counter_asserts_i (.*);

/* File: sim/digit_counter_test.sv */
// self-checking bench for the counting display decade
`timescale 1ns/1ps
module digit_counter_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic run = 1'b0;
    logic [6:0] ctl = 7'h32;
    logic counter_clear_n, lookahead_enable_n, ripple_enable_n, latch_hold_strobe;
    logic force_blank, zero_blank_in_n, ext_pull, count_clk, zero_blank_node_in;
    logic zero_blank_out_n, zero_blank_oe, terminal_count_n, point_on;
    logic point_in = 1'b1;
    logic [3:0] latch_q;
    logic [6:0] segments;
    int fail_count = 0;
    int comparisons = 0;
    // control pins as one vector; the previous decade's blank output is zero_blank_in_n
    assign {counter_clear_n, lookahead_enable_n, ripple_enable_n, latch_hold_strobe,
        force_blank, zero_blank_in_n, ext_pull} = ctl;
    always #5 clk = ~clk;
    far_side far_side_i (.*);
    digit_counter digit_counter_i (.*);
    // apply controls, send n count pulses, let the filters settle, compare
    task automatic step(input string nm, input logic [6:0] c, input int n, input logic [15:0] e);
        logic [15:0] seen;
        @(negedge clk) ctl = c;
        repeat (16) @(negedge clk);
        if (n > 0) begin
            run = 1'b1;
            repeat (n * 8) @(negedge clk);
            run = 1'b0;
        end
        repeat (16) @(negedge clk);
        seen = {1'b0, zero_blank_out_n, zero_blank_oe, point_on, latch_q, terminal_count_n,
            segments};
        comparisons++;
        if (seen !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
        end
    endtask : step
    task automatic counting;
        step("nine", 7'h42, 9, 16'h196F);
        step("serial off", 7'h52, 0, 16'h19EF);
        step("serial stop", 7'h52, 2, 16'h19EF);
        step("parallel stop", 7'h62, 2, 16'h196F);
        step("wrap", 7'h42, 1, 16'h10BF);
    endtask : counting
    task automatic holding;
        step("held", 7'h4A, 2, 16'h10BF);
        step("follow", 7'h42, 0, 16'h12DB);
    endtask : holding
    task automatic blanking;
        step("forced", 7'h44, 0, 16'h2280);
        step("not zero", 7'h40, 0, 16'h12DB);
        step("zero off", 7'h00, 0, 16'h2080);
        step("zero on", 7'h02, 0, 16'h10BF);
        step("node low", 7'h03, 0, 16'h0080);
        @(negedge clk) point_in = 1'b0;
        step("point off", 7'h42, 0, 16'h00BF);
        point_in = 1'b1;
    endtask : blanking
    // verdict, reached from the main sequence or the watchdog
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    // reset with clear held, so the filter's first rising edge cannot count
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (16) @(negedge clk);
        counting();
        holding();
        blanking();
        tally_and_finish();
    end
    // watchdog: the scenarios need well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end
endmodule : digit_counter_test
